// >>> design/blme_exec.sv
// Execution datapath for seven baseline core instructions
module blme_exec
  import blme_pkg::*;
#(
  parameter int P_DATA_W = DATA_W
) (
  input  wire logic                i_clk_sys,   // Core clock
  input  wire logic                i_srst,      // Sync reset, high
  input  wire logic                i_ce,        // Clock enable
  input  wire logic [INSN_W-1:0]   i_insn,      // Instruction word
  input  wire logic                i_insn_vld,  // Instruction present
  input  wire logic [DATA_W-1:0]   i_file_rd,   // Addressed file value
  output logic      [FADDR_W-1:0]  o_file_addr, // File address
  output logic      [DATA_W-1:0]   o_file_wd,   // File write data
  output logic                     o_file_we,   // File write pulse
  output logic      [DATA_W-1:0]   o_acc,       // Accumulator
  output logic      [2:0]          o_flags,     // Z, NC, C
  output logic      [DATA_W-1:0]   o_pdir5,     // Pin direction 5
  output logic      [DATA_W-1:0]   o_pdir6,     // Pin direction 6
  output logic      [DATA_W-1:0]   o_pdir7,     // Pin direction 7
  output logic                     o_cyc_end,   // Instruction done pulse
  output logic                     o_unknown    // Opcode not handled
);
  // Datapath is built for an 8-bit word only
  if (P_DATA_W != DATA_W) begin : g_bad_width
    $error("blme_exec: width must be 8");
  end

  function automatic logic zero_of(input logic [7:0] v);
    zero_of = (v == 8'h0_000);
  endfunction : zero_of

  blme_phase_t phase_reg, phase_next;
  logic [11:0] insn_reg;

  // Four phases per instruction cycle
  always_comb begin
    case (phase_reg)
      BLME_Q1: phase_next = BLME_Q2;
      BLME_Q2: phase_next = BLME_Q3;
      BLME_Q3: phase_next = BLME_Q4;
      BLME_Q4: phase_next = BLME_Q1;
      default: phase_next = BLME_Q1;
    endcase
  end

  wire       q1      = (phase_reg == BLME_Q1);
  wire       q4      = (phase_reg == BLME_Q4);
  wire [4:0] faddr   = insn_reg[FADDR_W-1:0];
  wire       dest_f  = insn_reg[DEST_BIT];
  wire [7:0] kimm    = insn_reg[7:0];
  wire       is_iorl = insn_reg[11:8] == OPN_OR_IMM;
  wire       is_movl = insn_reg[11:8] == OPN_LOAD_IMM;
  wire       is_iorf = insn_reg[11:6] == OPB_OR_FILE;
  wire       is_file_copy = insn_reg[11:6] == OPB_FILE_COPY;
  wire       is_subf = insn_reg[11:6] == OPB_SUB_FILE;
  wire       is_swpf = insn_reg[11:6] == OPB_NIB_EXCH;
  wire       is_pin_direction_reg = insn_reg[11:3] == OPT_PIN_DIR
                       && insn_reg[2:0] >= PDIR_LO
                       && insn_reg[2:0] <= PDIR_HI;
  wire       is_file = is_iorf | is_file_copy | is_subf | is_swpf;
  wire       known   = is_iorl | is_movl | is_file | is_pin_direction_reg;

  // Subtract as f + ~w + 1
  wire [8:0] sub_sum = {1'b0, i_file_rd} + {1'b0, ~o_acc} + 9'h0_001;
  wire [4:0] sub_lo  = {1'b0, i_file_rd[3:0]} + {1'b0, ~o_acc[3:0]}
                       + 5'h0_001;

  logic [7:0] res;
  always_comb begin
    res = i_file_rd;
    if (is_iorl) res = o_acc | kimm;
    if (is_movl) res = kimm;
    if (is_iorf) res = o_acc | i_file_rd;
    if (is_subf) res = sub_sum[7:0];
    if (is_swpf) res = {i_file_rd[3:0], i_file_rd[7:4]};
  end

  wire        upd_z  = is_iorl | is_iorf | is_file_copy | is_subf;
  wire        wr_acc = is_iorl | is_movl | (is_file & ~dest_f);
  wire        wr_f   = is_file & dest_f;
  logic [2:0] flags_next;
  always_comb begin
    flags_next = o_flags;
    if (upd_z) flags_next[FLAG_Z] = zero_of(res);
    if (is_subf) begin
      flags_next[FLAG_C]  = sub_sum[8];
      flags_next[FLAG_NC] = sub_lo[4];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      phase_reg     <= BLME_Q1;
      insn_reg      <= 12'h0_000;
      o_file_addr   <= 5'h0_000;
      o_file_wd     <= 8'h0_000;
      o_file_we     <= 1'b0;
      o_acc         <= ACC_RST;
      o_flags       <= FLAGS_RST;
      o_pdir5       <= PDIR_RST;
      o_pdir6       <= PDIR_RST;
      o_pdir7       <= PDIR_RST;
      o_cyc_end     <= 1'b0;
      o_unknown     <= 1'b0;
    end else if (i_ce) begin
      phase_reg <= phase_next;
      o_file_we <= 1'b0;
      o_cyc_end <= 1'b0;
      if (q1) begin
        insn_reg    <= i_insn_vld ? i_insn : 12'h0_000;
        o_file_addr <= i_insn[FADDR_W-1:0];
      end
      if (q4) begin
        o_cyc_end <= 1'b1;
        o_unknown <= ~known & (insn_reg != 12'h0_000);
        o_flags   <= flags_next;
        if (wr_acc) o_acc <= res;
        if (wr_f) begin
          o_file_wd <= res;
          o_file_we <= 1'b1;
        end
        if (is_pin_direction_reg) begin
          if (insn_reg[2:0] == 3'h0_005) o_pdir5 <= o_acc;
          if (insn_reg[2:0] == 3'h0_006) o_pdir6 <= o_acc;
          if (insn_reg[2:0] == 3'h0_007) o_pdir7 <= o_acc;
        end
      end
    end
  end

  AST_PHASE4: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_cyc_end && i_ce ##1 i_ce ##1 i_ce ##1 i_ce |=> o_cyc_end)
    else $error("cycle end not every four clocks");
  AST_MOVL: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_movl |=> o_acc == $past(kimm) && $stable(o_flags))
    else $error("load immediate wrong");
  AST_IORL: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_iorl |=> o_acc == ($past(o_acc) | $past(kimm)))
    else $error("or immediate wrong");
  AST_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && upd_z |=> o_flags[FLAG_Z] == ($past(res) == 8'h0_000))
    else $error("zero flag wrong");
  AST_DESTF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_file && dest_f |=> o_file_we && $stable(o_acc))
    else $error("file destination wrong");
  AST_SUBC: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_subf |=>
      o_flags[FLAG_C] == ($past(i_file_rd) >= $past(o_acc)))
    else $error("subtract carry wrong");
  AST_SWAP: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_swpf |=> $stable(o_flags))
    else $error("nibble exchange touched flags");
  AST_FILE_COPY: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_file_copy && dest_f |=> o_file_wd == $past(i_file_rd))
    else $error("self copy changed value");
  AST_PIN_DIRECTION_REG: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_pin_direction_reg && insn_reg[2:0] == 3'h0_006
      |=> o_pdir6 == $past(o_acc) && $stable(o_flags))
    else $error("pin direction load wrong");
  AST_IORF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_iorf && !dest_f
      |=> o_acc == ($past(o_acc) | $past(i_file_rd)))
    else $error("or file wrong");

  AST_FILE_COPY_ACC: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_file_copy && !dest_f |=> o_acc == $past(i_file_rd))
    else $error("file copy to accumulator wrong");

  AST_SUB_RES: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_subf && !dest_f
      |=> o_acc == 8'($past(i_file_rd) - $past(o_acc)))
    else $error("subtract result wrong");

  AST_SUB_NC: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_subf
      |=> o_flags[FLAG_NC] == ($past(i_file_rd[3:0]) >= $past(o_acc[3:0])))
    else $error("subtract nibble carry wrong");

  AST_SWAP_VAL: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && is_swpf && !dest_f
      |=> o_acc == {$past(i_file_rd[3:0]), $past(i_file_rd[7:4])})
    else $error("nibble exchange value wrong");

  AST_ADDR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q1 |=> o_file_addr == $past(i_insn[FADDR_W-1:0]))
    else $error("file address not latched");

  AST_NO_WE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && !wr_f |=> !o_file_we)
    else $error("file written for accumulator destination");

  AST_FROZEN: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !i_ce |=> $stable(o_acc) && $stable(o_flags) && $stable(o_cyc_end))
    else $error("state moved with clock enable low");

  AST_UNKNOWN: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && !known && insn_reg != 12'h0_000
      |=> o_unknown && $stable(o_acc) && $stable(o_flags))
    else $error("unhandled opcode changed state");

  AST_PDIR_KEEP: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_ce && q4 && !is_pin_direction_reg
      |=> $stable(o_pdir5) && $stable(o_pdir6) && $stable(o_pdir7))
    else $error("pin direction changed without load");

  AST_CYC_PULSE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_cyc_end && i_ce |=> !o_cyc_end)
    else $error("cycle end longer than one clock");
endmodule : blme_exec

// >>> design/blme_pkg.sv
// Package: opcodes, field positions, flag positions and timing for executor
package blme_pkg;
  localparam int         INSN_W          = 12;
  localparam int         DATA_W          = 8;
  localparam int         FADDR_W         = 5;
  localparam int         QPHASES         = 4;
  localparam int         DEST_BIT        = 5;
  localparam int         FLAG_C          = 0;
  localparam int         FLAG_NC         = 1;
  localparam int         FLAG_Z          = 2;
  localparam logic [3:0] OPN_OR_IMM      = 4'h0_00d;
  localparam logic [3:0] OPN_LOAD_IMM    = 4'h0_00c;
  localparam logic [5:0] OPB_OR_FILE     = 6'h0_004;
  localparam logic [5:0] OPB_FILE_COPY   = 6'h0_008;
  localparam logic [5:0] OPB_SUB_FILE    = 6'h0_002;
  localparam logic [5:0] OPB_NIB_EXCH    = 6'h0_00e;
  localparam logic [8:0] OPT_PIN_DIR     = 9'h0_000;
  localparam logic [2:0] PDIR_LO         = 3'h0_005;
  localparam logic [2:0] PDIR_HI         = 3'h0_007;
  localparam logic [7:0] ACC_RST         = 8'h0_000;
  localparam logic [7:0] PDIR_RST        = 8'h0_0ff;
  localparam logic [2:0] FLAGS_RST       = 3'h0_000;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
    logic       we;
  } blme_fwr_t;

  typedef enum logic [1:0] {
    BLME_Q1 = 2'b00,
    BLME_Q2 = 2'b01,
    BLME_Q3 = 2'b10,
    BLME_Q4 = 2'b11
  } blme_phase_t;
endpackage : blme_pkg

// >>> dv/blme_file_model.sv
// Register file model on the far side of the executor
module blme_file_model
  import blme_pkg::*;
(
  input  wire logic               i_clk_sys, // Core clock
  input  wire logic               i_srst,    // Sync reset, high
  input  wire logic [FADDR_W-1:0] i_addr,    // File address
  input  wire logic [DATA_W-1:0]  i_wd,      // Write data
  input  wire logic               i_we,      // Write pulse
  output logic      [DATA_W-1:0]  o_rd       // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem_reg [32];
  assign o_rd = mem_reg[i_addr];
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (int i = 0; i < 32; i++) begin
        mem_reg[i] <= DATA_W'(i); // Each cell starts at its own address
      end
    end else if (i_we) begin
      mem_reg[i_addr] <= i_wd;
    end
  end
endmodule : blme_file_model

// >>> dv/tb_baseline_logic_move_sub_exec.sv
// Self-checking bench for the baseline executor datapath
module tb_baseline_logic_move_sub_exec
  import blme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] insn;
    logic [7:0]  acc;
    logic [2:0]  flg;
    logic        we;
    logic [7:0]  wd;
  } blme_row_t;
  localparam int NR = 21;
  logic i_clk_sys, i_srst, i_ce, i_insn_vld;
  logic [INSN_W-1:0]  i_insn;
  logic [DATA_W-1:0]  i_file_rd, o_file_wd, o_acc, o_pdir5, o_pdir6, o_pdir7;
  logic [FADDR_W-1:0] o_file_addr;
  logic [2:0]         o_flags;
  logic               o_file_we, o_cyc_end, o_unknown;
  int fail_count, samples_checked;
  blme_row_t rows [NR] = '{
    '{12'hC35, 8'h35, 3'h0, 1'b0, 8'h00}, '{12'hD80, 8'hB5, 3'h0, 1'b0, 8'h00},
    '{12'hC00, 8'h00, 3'h0, 1'b0, 8'h00}, '{12'hD00, 8'h00, 3'h4, 1'b0, 8'h00},
    '{12'h213, 8'h13, 3'h0, 1'b0, 8'h00}, '{12'h10C, 8'h1F, 3'h0, 1'b0, 8'h00},
    '{12'h09F, 8'h00, 3'h7, 1'b0, 8'h00}, '{12'hC02, 8'h02, 3'h7, 1'b0, 8'h00},
    '{12'h081, 8'hFF, 3'h0, 1'b0, 8'h00}, '{12'hC21, 8'h21, 3'h0, 1'b0, 8'h00},
    '{12'h0B3, 8'h21, 3'h2, 1'b1, 8'hF2}, '{12'h393, 8'h2F, 3'h2, 1'b0, 8'h00},
    '{12'h233, 8'h2F, 3'h2, 1'b1, 8'hF2}, '{12'h3B3, 8'h2F, 3'h2, 1'b1, 8'h2F},
    '{12'h006, 8'h2F, 3'h2, 1'b0, 8'h00}, '{12'hC5A, 8'h5A, 3'h2, 1'b0, 8'h00},
    '{12'h005, 8'h5A, 3'h2, 1'b0, 8'h00}, '{12'hC77, 8'h77, 3'h2, 1'b0, 8'h00},
    '{12'h007, 8'h77, 3'h2, 1'b0, 8'h00}, '{12'h125, 8'h77, 3'h2, 1'b1, 8'h77},
    '{12'h008, 8'h77, 3'h2, 1'b0, 8'h00}
  };
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  blme_exec dut_u (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce), .i_insn(i_insn),
    .i_insn_vld(i_insn_vld), .i_file_rd(i_file_rd),
    .o_file_addr(o_file_addr), .o_file_wd(o_file_wd), .o_file_we(o_file_we),
    .o_acc(o_acc), .o_flags(o_flags), .o_pdir5(o_pdir5), .o_pdir6(o_pdir6),
    .o_pdir7(o_pdir7), .o_cyc_end(o_cyc_end), .o_unknown(o_unknown)
  );
  blme_file_model file_u (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(o_file_addr),
    .i_wd(o_file_wd), .i_we(o_file_we), .o_rd(i_file_rd)
  );
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    i_srst = 1'b1;
    i_ce = 1'b1;
    i_insn_vld = 1'b1;
    i_insn = 12'h000;
    repeat (9) @(posedge i_clk_sys);
    #1;
    chk("acc_rst", 8'h00, o_acc);
    chk("flags_rst", 8'h00, {5'h00, o_flags});
    chk("pdir_rst", 8'hFF, o_pdir5 & o_pdir6 & o_pdir7);
    @(posedge i_clk_sys);
    i_srst <= 1'b0;
    i_insn <= rows[0].insn;
    // Next word goes out on the Q4 edge, checks land just after it
    for (int i = 0; i < NR; i++) begin
      repeat (4) @(posedge i_clk_sys);
      if (i + 1 < NR) begin
        i_insn <= rows[i + 1].insn;
      end else begin
        i_insn_vld <= 1'b0; // Next word is not valid
        i_insn     <= 12'hC99;
      end
      #1;
      chk("cyc_end", 8'h01, {7'h00, o_cyc_end});
      chk("acc", rows[i].acc, o_acc);
      chk("flags", {5'h00, rows[i].flg}, {5'h00, o_flags});
      chk("file_we", {7'h00, rows[i].we}, {7'h00, o_file_we});
      if (rows[i].we) chk("file_wd", rows[i].wd, o_file_wd);
      chk("unknown", {7'h00, i == NR - 1}, {7'h00, o_unknown});
      chk("file_addr", {3'h0, rows[i].insn[4:0]}, {3'h0, o_file_addr});
    end
    chk("pdir5", 8'h5A, o_pdir5);
    chk("pdir6", 8'h2F, o_pdir6);
    chk("pdir7", 8'h77, o_pdir7);
    // Invalid word executes nothing
    repeat (4) @(posedge i_clk_sys);
    i_insn_vld <= 1'b1;
    i_insn     <= 12'hC33;
    #1;
    chk("nop_acc", 8'h77, o_acc);
    chk("nop_flags", 8'h02, {5'h00, o_flags});
    chk("nop_unknown", 8'h00, {7'h00, o_unknown});
    chk("nop_cyc_end", 8'h01, {7'h00, o_cyc_end});
    // Clock enable low freezes mid instruction
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    #1;
    chk("ce_acc", 8'h77, o_acc);
    chk("ce_cyc_end", 8'h00, {7'h00, o_cyc_end});
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk("ce_acc_done", 8'h33, o_acc);
    chk("ce_cyc_end_done", 8'h01, {7'h00, o_cyc_end});
    // Reset in mid-run
    @(posedge i_clk_sys);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk("mid_rst_acc", 8'h00, o_acc);
    chk("mid_rst_flags", 8'h00, {5'h00, o_flags});
    chk("mid_rst_pdir", 8'hFF, o_pdir5 & o_pdir6 & o_pdir7);
    chk("mid_rst_we", 8'h00, {7'h00, o_file_we});
    @(posedge i_clk_sys);
    i_srst <= 1'b0;
    i_insn <= 12'hC44;
    repeat (4) @(posedge i_clk_sys);
    #1;
    chk("post_rst_acc", 8'h44, o_acc);
    chk("post_rst_cyc_end", 8'h01, {7'h00, o_cyc_end});
    complete_run();
  end
endmodule : tb_baseline_logic_move_sub_exec
